// file: verilog/lcdctl_top.sv
// What this block does
// - min mode, battery above threshold: bias from battery, pump off.
// - min mode, battery below threshold: charge pump on automatically.
// - const mode, battery above threshold: bias via variable resistance.
// - const mode, battery below threshold: charge pump on automatically.
// - divider code 2 divides by 2, each higher code doubles, to 4096.
// - toggle rate is refresh times mux times 2 over divider ratio.
// - upper four toggle register bits read zero, writes ignored.
`timescale 1ns/100ps
`default_nettype none

module lcdctl_top (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output var  logic [7:0] sfr_rdata,
  input  wire logic       lcd_mode_ctrl_sel,
  input  wire logic       lcd_mode_cfg_min,
  input  wire logic       lcd_power_ctrl_en,
  input  wire logic       battery_monitor_ctrl_en,
  input  wire logic       battery_below_thresh,
  input  wire logic       base_tick,
  output var  logic       charge_pump_en,
  output var  logic       bias_direct_en,
  output var  logic       bias_regulate_en,
  output var  logic [1:0] contrast_mode,
  output var  logic       toggle_tick
);

  // =====================================================================
  // supply path decode
  // one path decision, shared by pump, direct and regulated paths
  function automatic logic path_on(
    input logic want,
    input logic below,
    input logic want_below
  );
    return want && (below == want_below);
  endfunction

  // =====================================================================
  // register file
  // only the divider select is stored; unused bits cost no flops
  logic [3:0] toggle_divider_sel;
  logic [3:0] next_toggle_divider_sel;
  logic [7:0] next_sfr_rdata;

  // =====================================================================
  // address decode
  // one decode serves both strobes, so they cannot disagree
  wire hit_toggle = (sfr_addr == lcdctl_pkg::TOGGLE_RATE_ADDR);
  wire wr_toggle  = sfr_wr && hit_toggle;
  wire rd_toggle  = sfr_rd && hit_toggle;

  // =====================================================================
  // write path
  // upper nibble is not stored, so it can never read back non-zero
  assign next_toggle_divider_sel =
    wr_toggle ? sfr_wdata[lcdctl_pkg::TOGGLE_SEL_LSB +: 4]
              : toggle_divider_sel;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_divider_sel <=
        lcdctl_pkg::TOGGLE_RATE_RESET[lcdctl_pkg::TOGGLE_SEL_LSB +: 4];
    end else begin
      toggle_divider_sel <= next_toggle_divider_sel;
    end
  end

  // =====================================================================
  // read path
  // registered read data: the answer comes one cycle after the strobe
  // an idle bus reads zero, so a stray read shows nothing stale
  assign next_sfr_rdata =
    rd_toggle ? {4'h0, toggle_divider_sel} : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // =====================================================================
  // contrast mode decode
  // decoded combinationally; no sequencing needed between bit writes
  wire common_on = lcd_power_ctrl_en && battery_monitor_ctrl_en;
  wire min_sel   = common_on && !lcd_mode_ctrl_sel &&
                   lcd_mode_cfg_min;
  wire const_sel = common_on && lcd_mode_ctrl_sel &&
                   !lcd_mode_cfg_min;
  wire any_cfg   = lcd_mode_ctrl_sel || lcd_mode_cfg_min || common_on;

  lcdctl_pkg::lcdctl_mode_t mode;
  lcdctl_pkg::lcdctl_mode_t next_mode;

  always_comb begin
    case ({min_sel, const_sel})
      2'b10:   next_mode = lcdctl_pkg::LCDCTL_MIN;
      2'b01:   next_mode = lcdctl_pkg::LCDCTL_CONST;
      default: next_mode = any_cfg ? lcdctl_pkg::LCDCTL_OTHER
                                   : lcdctl_pkg::LCDCTL_OFF;
    endcase
  end

  // =====================================================================
  // supply path selection
  // other modes belong to other logic; here they leave all paths off
  wire is_min   = (next_mode == lcdctl_pkg::LCDCTL_MIN);
  wire is_const = (next_mode == lcdctl_pkg::LCDCTL_CONST);
  wire pump_ok  = is_min || is_const;

  // flags come from next_mode so outputs and reported mode agree
  wire next_charge_pump_en =
    path_on(pump_ok, battery_below_thresh, 1'b1);
  wire next_bias_direct_en =
    path_on(is_min, battery_below_thresh, 1'b0);
  wire next_bias_regulate_en =
    path_on(is_const, battery_below_thresh, 1'b0);

  // =====================================================================
  // mode register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= lcdctl_pkg::LCDCTL_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  assign contrast_mode = mode;

  // =====================================================================
  // charge pump
  // pump follows the monitor only in min and const modes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      charge_pump_en <= 1'b0;
    end else begin
      charge_pump_en <= next_charge_pump_en;
    end
  end

  // =====================================================================
  // direct bias path
  // never on together with the pump, so the battery is not shorted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bias_direct_en <= 1'b0;
    end else begin
      bias_direct_en <= next_bias_direct_en;
    end
  end

  // =====================================================================
  // regulated bias path
  // limitation: the regulation loop itself sits in the analog part
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bias_regulate_en <= 1'b0;
    end else begin
      bias_regulate_en <= next_bias_regulate_en;
    end
  end

  // =====================================================================
  // toggle rate divider
  lcdctl_div_if div_bus ();

  // reserved codes stop the divider instead of guessing a ratio
  assign div_bus.div_sel   = toggle_divider_sel;
  assign div_bus.base_tick = base_tick;

  lcdctl_toggle_div u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .dv      (div_bus.div)
  );

  assign toggle_tick = div_bus.toggle_tick;

endmodule // lcdctl_top

`default_nettype wire

// file: common/lcdctl_pkg.sv
package lcdctl_pkg;

  // =====================================================================
  // register map
  localparam logic [7:0] TOGGLE_RATE_ADDR  = 8'h9F;
  localparam logic [7:0] TOGGLE_RATE_RESET = 8'h00;
  localparam int         TOGGLE_SEL_LSB    = 0;
  localparam int         TOGGLE_SEL_W      = 4;

  // =====================================================================
  // configuration bit positions of the surrounding mode registers
  localparam int MODE_CTRL_SEL_BIT  = 2;
  localparam int MODE_CFG_MIN_BIT   = 0;
  localparam int POWER_CTRL_EN_BIT  = 3;
  localparam int BATT_MON_EN_BIT    = 7;

  // =====================================================================
  // toggle divider codes
  localparam logic [3:0] TOGGLE_SEL_MIN    = 4'h2;
  localparam logic [3:0] TOGGLE_SEL_MAX    = 4'hD;
  localparam int         TOGGLE_CNT_W      = 12;
  localparam int         TOGGLE_MAX_RATIO  = 4096;
  localparam int         TOGGLE_BASE_TICKS = 2;

  // =====================================================================
  // contrast modes, gray coded along off -> min -> const
  typedef enum logic [1:0] {
    LCDCTL_OFF   = 2'b00,
    LCDCTL_MIN   = 2'b01,
    LCDCTL_CONST = 2'b11,
    LCDCTL_OTHER = 2'b10
  } lcdctl_mode_t;

  // reserved codes leave the divider stopped
  function automatic logic lcdctl_sel_valid(input logic [3:0] sel);
    return (sel >= TOGGLE_SEL_MIN) && (sel <= TOGGLE_SEL_MAX);
  endfunction

  // terminal count: code 2 divides by 2, each step doubles
  function automatic logic [11:0] lcdctl_sel_limit(input logic [3:0] sel);
    logic [11:0] one;
    one = 12'h001;
    return (one << (sel - 4'h1)) - 12'h001;
  endfunction

endpackage

// file: common/lcdctl_div_if.sv
`timescale 1ns/100ps
`default_nettype none

interface lcdctl_div_if;
  logic [3:0] div_sel;
  logic       base_tick;
  logic       toggle_tick;

  modport ctrl (
    output div_sel,
    output base_tick,
    input  toggle_tick
  );

  modport div (
    input  div_sel,
    input  base_tick,
    output toggle_tick
  );
endinterface

`default_nettype wire

// file: verilog/lcdctl_toggle_div.sv
`timescale 1ns/100ps
`default_nettype none

module lcdctl_toggle_div (
  input  wire logic   clk,
  input  wire logic   reset_n,
  lcdctl_div_if.div   dv
);

  logic [11:0] count;
  logic [11:0] next_count;
  logic        next_tick;
  logic        tick;
  wire         sel_ok = lcdctl_pkg::lcdctl_sel_valid(dv.div_sel);
  wire  [11:0] limit  = lcdctl_pkg::lcdctl_sel_limit(dv.div_sel);
  wire         at_end = (count >= limit);

  // =====================================================================
  // divide base ticks by the selected power of two
  // base ticks arrive at refresh x mux x 2; output is that over the ratio
  assign next_count = !sel_ok ? 12'h000 :
                      !dv.base_tick ? count :
                      at_end ? 12'h000 : count + 12'h001;
  assign next_tick  = sel_ok && dv.base_tick && at_end;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 12'h000;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

  assign dv.toggle_tick = tick;

endmodule // lcdctl_toggle_div

`default_nettype wire

// file: tb/lcdctl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module lcdctl_checker (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       lcd_mode_ctrl_sel,
  input wire logic       lcd_mode_cfg_min,
  input wire logic       lcd_power_ctrl_en,
  input wire logic       battery_monitor_ctrl_en,
  input wire logic       battery_below_thresh,
  input wire logic       charge_pump_en,
  input wire logic       bias_direct_en,
  input wire logic       bias_regulate_en,
  input wire logic [1:0] contrast_mode,
  input wire logic       toggle_tick
);
  // ====================
  // mode decode helpers
  wire en = lcd_power_ctrl_en & battery_monitor_ctrl_en;
  wire mn = en & ~lcd_mode_ctrl_sel & lcd_mode_cfg_min;
  wire cn = en & lcd_mode_ctrl_sel & ~lcd_mode_cfg_min;
  wire lo = battery_below_thresh;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_upper: assert property (sfr_rdata[7:4] == 4'h0)
    else $error("upper read bits set");
  a_rdata_unmapped: assert property (sfr_rd && sfr_addr != 8'h9F |=>
    sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_min_mode: assert property (mn |=> contrast_mode == 2'h1)
    else $error("min mode not reported");
  a_min_direct: assert property (mn && !lo |=> bias_direct_en &&
    !charge_pump_en) else $error("min mode not direct");
  a_min_pump: assert property (mn && lo |=> charge_pump_en &&
    !bias_direct_en) else $error("min mode pump off");
  a_const_reg: assert property (cn && !lo |=> bias_regulate_en &&
    !charge_pump_en && contrast_mode == 2'h3) else $error("const not reg");
  a_const_pump: assert property (cn && lo |=> charge_pump_en)
    else $error("const mode pump off");
  a_other_off: assert property (!mn && !cn |=> !(charge_pump_en ||
    bias_direct_en || bias_regulate_en)) else $error("supply on in other");
  a_tick_pulse: assert property (toggle_tick |=> !toggle_tick)
    else $error("toggle tick too long");
  cover property (mn && lo);
  cover property (cn && !lo);
  cover property (toggle_tick);
endmodule // lcdctl_checker
bind lcdctl_top lcdctl_checker chk_i (.*);
`default_nettype wire

// file: tb/test_lcd_contrast_toggle_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_lcd_contrast_toggle_ctrl;
  logic       clk = 0, reset_n = 0, wr = 0, rd = 0, base = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, q;
  logic [4:0] cfg = 5'h00;
  logic       pump, dir, breg, tick;
  logic [1:0] mode;
  int         err_count = 0, compares = 0, ticks = 0, t0 = 0;
  // ====================
  // expected supply state
  wire en = cfg[2] & cfg[3];
  wire mn = en & ~cfg[0] & cfg[1];
  wire cn = en & cfg[0] & ~cfg[1];
  wire [1:0] em = mn ? 2'h1 : cn ? 2'h3 :
                  (cfg[0] | cfg[1] | en) ? 2'h2 : 2'h0;
  wire [2:0] es = {(mn | cn) & cfg[4], mn & ~cfg[4], cn & ~cfg[4]};
  always #50 clk = ~clk;
  always @(posedge clk) ticks <= ticks + int'(tick);
  lcdctl_top uut (.clk(clk), .reset_n(reset_n), .sfr_addr(addr),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdata),
    .lcd_mode_ctrl_sel(cfg[0]), .lcd_mode_cfg_min(cfg[1]),
    .lcd_power_ctrl_en(cfg[2]), .battery_monitor_ctrl_en(cfg[3]),
    .battery_below_thresh(cfg[4]), .base_tick(base),
    .charge_pump_en(pump), .bias_direct_en(dir), .bias_regulate_en(breg),
    .contrast_mode(mode), .toggle_tick(tick));
  task automatic chk(input string n, input logic [15:0] e, s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // read data stands in the cycle after the strobe, sampled there
  task automatic sfr(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 0;
    rd = 0;
    q = rdata;
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #8000000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1;
    sfr(0, 8'h9F, 8'h00);
    chk("reset", 16'h0000, {8'h00, q});
    sfr(1, 8'h9E, 8'h0F);
    sfr(0, 8'h9E, 8'h00);
    chk("unmapped", 16'h0000, {8'h00, q});
    // every combination of the four bits and the battery level
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      cfg = 5'(i);
      @(negedge clk);
      chk("mode", {14'h0000, em}, {14'h0000, mode});
      chk("supply", {13'h0000, es}, {13'h0000, pump, dir, breg});
    end
    // code 0 first parks the divider so each count starts clean
    for (int c = 0; c < 16; c++) begin
      sfr(1, 8'h9F, 8'h00);
      sfr(1, 8'h9F, 8'hF0 | 8'(c));
      sfr(0, 8'h9F, 8'h00);
      chk("sel", {12'h000, 4'(c)}, {8'h00, q});
      @(negedge clk);
      t0 = ticks;
      base = 1;
      repeat (4096) @(negedge clk);
      base = 0;
      repeat (2) @(negedge clk);
      chk("ticks", (c >= 2 && c <= 13) ? 16'(4096 >> (c - 1)) : 16'h0000,
        16'(ticks - t0));
    end
    test_done();
  end
endmodule // test_lcd_contrast_toggle_ctrl
`default_nettype wire
